//--- rbd_address_decoder.sv
// register group address decoder: holds the address, decodes it, steers accesses
// assumes byte-load and access pulses come from command logic on core_clk
`timescale 1ns/10ps
module rbd_address_decoder (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // address byte commands
  input wire logic addrHiWe,
  input wire logic addrLoWe,
  input wire logic [7:0] addrByte,
  // indirect mode
  input wire logic indirectMode,
  input wire logic [7:0] offsetVal,
  // access request
  input wire logic accValid,
  input wire logic accWrite,
  input wire logic [7:0] accWdata,
  // read data from the groups, one byte per slot
  input wire logic [7:0][7:0] grpRdata,
  // held address and decoded fields
  output logic [15:0] addrCur,
  output logic [3:0] grpNum,
  output logic [7:0] grpSel,
  output logic [5:0] regIdx,
  output logic [5:0] regionAddr,
  output logic regionFlag,
  output logic [4:0] regMask,
  output logic [2:0] frameIdx,
  output logic halfSel,
  // access strobes and data
  output logic [7:0] grpWrStb,
  output logic [7:0] grpRdStb,
  output logic [7:0] wrData,
  output logic [7:0] rdData,
  output logic rdValid,
  output logic unmappedAcc
);
  // ****************************************
  // address register
  // ****************************************
  logic [15:0] addr_r;
  logic [15:0] addr_nxt;

  always_comb begin
    addr_nxt = addr_r;
    if (addrHiWe) begin
      addr_nxt[15:8] = addrByte;
    end
    if (addrLoWe) begin
      addr_nxt[7:0] = addrByte;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      addr_r <= rbd_pkg::ADDR_RESET;
    end else begin
      addr_r <= addr_nxt;
    end
  end

  // ****************************************
  // field decode
  // ****************************************
  rbd_field_if fld ();

  assign fld.addr = addr_r;
  assign fld.offset = offsetVal;
  assign fld.indirect = indirectMode;

  rbd_field_decode u_decode (
    .f (fld.dec)
  );

  // ****************************************
  // registered fields and access strobes
  // ****************************************
  logic [3:0] grp_r, grp_nxt;
  logic [7:0] sel_r, sel_nxt;
  logic [5:0] idx_r, idx_nxt;
  logic [5:0] region_r, region_nxt;
  logic flag_r, flag_nxt;
  logic [4:0] mask_r, mask_nxt;
  logic [2:0] frame_r, frame_nxt;
  logic half_r, half_nxt;
  logic [7:0] wrStb_r, wrStb_nxt;
  logic [7:0] rdStb_r, rdStb_nxt;
  logic [7:0] wrData_r, wrData_nxt;
  logic [7:0] rdData_r, rdData_nxt;
  logic rdValid_r, rdValid_nxt;
  logic unmapped_r, unmapped_nxt;
  logic [7:0] slotHot;

  assign slotHot = fld.mapped ? (8'h01 << fld.slot) : 8'h00;

  always_comb begin
    grp_nxt = fld.grp;
    sel_nxt = slotHot;
    idx_nxt = fld.regIdx;
    region_nxt = fld.region;
    flag_nxt = fld.regionFlag;
    mask_nxt = fld.mask;
    frame_nxt = fld.frame;
    half_nxt = fld.half;
    wrStb_nxt = 8'h00;
    rdStb_nxt = 8'h00;
    wrData_nxt = wrData_r;
    rdData_nxt = rdData_r;
    rdValid_nxt = 1'b0;
    unmapped_nxt = 1'b0;
    if (accValid) begin
      unmapped_nxt = !fld.mapped;
      if (accWrite) begin
        wrData_nxt = accWdata;
        // monitoring values are never written
        wrStb_nxt = slotHot & ~(8'h01 << rbd_pkg::SLOT_MONITOR);
      end else begin
        rdStb_nxt = slotHot;
        rdValid_nxt = 1'b1;
        rdData_nxt = fld.mapped ? grpRdata[fld.slot] : 8'h00;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      grp_r <= 4'h0;
      sel_r <= 8'h00;
      idx_r <= 6'h00;
      region_r <= 6'h00;
      flag_r <= 1'b0;
      mask_r <= 5'h00;
      frame_r <= 3'h0;
      half_r <= 1'b0;
      wrStb_r <= 8'h00;
      rdStb_r <= 8'h00;
      wrData_r <= 8'h00;
      rdData_r <= 8'h00;
      rdValid_r <= 1'b0;
      unmapped_r <= 1'b0;
    end else begin
      grp_r <= grp_nxt;
      sel_r <= sel_nxt;
      idx_r <= idx_nxt;
      region_r <= region_nxt;
      flag_r <= flag_nxt;
      mask_r <= mask_nxt;
      frame_r <= frame_nxt;
      half_r <= half_nxt;
      wrStb_r <= wrStb_nxt;
      rdStb_r <= rdStb_nxt;
      wrData_r <= wrData_nxt;
      rdData_r <= rdData_nxt;
      rdValid_r <= rdValid_nxt;
      unmapped_r <= unmapped_nxt;
    end
  end

  assign addrCur = addr_r;
  assign grpNum = grp_r;
  assign grpSel = sel_r;
  assign regIdx = idx_r;
  assign regionAddr = region_r;
  assign regionFlag = flag_r;
  assign regMask = mask_r;
  assign frameIdx = frame_r;
  assign halfSel = half_r;
  assign grpWrStb = wrStb_r;
  assign grpRdStb = rdStb_r;
  assign wrData = wrData_r;
  assign rdData = rdData_r;
  assign rdValid = rdValid_r;
  assign unmappedAcc = unmapped_r;

  // ****************************************
  // assertions
  // ****************************************
  default clocking dcb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  a_hi_byte_load: assert property (addrHiWe |=> addrCur[15:8] == $past(addrByte))
    else $error("upper address byte not loaded");
  a_lo_keeps_hi: assert property (addrLoWe && !addrHiWe |=> addrCur[15:8] == $past(addrCur[15:8]))
    else $error("lower byte command disturbed upper byte");
  a_group_split: assert property (##1 grpNum == {$past(addrCur[15]), $past(addrCur[7:5])})
    else $error("group number not taken from bits 15 and 7 to 5");
  a_general_index: assert property ((addrCur[15:5] == 11'h001 && !indirectMode)
      |=> regIdx == {2'b00, $past(addrCur[3:0])} && grpSel == 8'h01)
    else $error("general register index wrong");
  a_seq_select: assert property ((grpNum == rbd_pkg::GRP_SEQUENCER) |-> grpSel == 8'h04)
    else $error("sequencer group not selected");
  a_pixel_fields: assert property ((addrCur[15] == 1'b0 && addrCur[7:5] == 3'h4 && !indirectMode)
      |=> regionAddr == $past(addrCur[13:8]) && regMask == $past(addrCur[4:0])
      && regionFlag == $past(addrCur[14]))
    else $error("pixel control fields wrong");
  a_monitor_ro: assert property (grpWrStb[4] == 1'b0)
    else $error("write strobe reached monitoring group");
  a_monitor_write_drop: assert property ((accValid && accWrite && !addrCur[15] && addrCur[7:5] == 3'h7)
      |=> grpWrStb == 8'h00 && !unmappedAcc)
    else $error("monitoring write not dropped as a mapped access");
  a_mfe_frame: assert property ((addrCur[15] && addrCur[7:5] == 3'h0)
      |=> frameIdx == $past(addrCur[2:0]) && grpSel == 8'h20)
    else $error("frame index wrong");
  a_half_select: assert property ((addrCur[15] && addrCur[7:5] == 3'h1)
      |=> halfSel == ($past(addrCur[0]) ^ ($past(indirectMode) & $past(offsetVal[0]))))
    else $error("half select wrong");
  a_rdtest_range: assert property ((accValid && fld.grp == rbd_pkg::GRP_RDTEST && fld.regIdx[4:0] > 5'h13)
      |=> grpWrStb == 8'h00 && unmappedAcc)
    else $error("readout test index above range accepted");
  a_unused_bits: assert property ((!addrCur[15] && addrCur[7:5] == 3'h1 && addrCur[14:8] != 7'h00 && !indirectMode)
      |=> regIdx == {2'b00, $past(addrCur[3:0])} && grpSel == 8'h01)
    else $error("unused bits changed the general index");
  a_indirect_idx: assert property ((addrCur[15:5] == 11'h001 && indirectMode)
      |=> regIdx[3:0] == 4'($past(addrCur[3:0]) + $past(offsetVal[3:0])))
    else $error("indirect index not combined with offset");
  a_unmapped_zero: assert property ((accValid && !fld.mapped)
      |=> grpWrStb == 8'h00 && grpRdStb == 8'h00 && (!rdValid || rdData == 8'h00))
    else $error("unassigned group access had an effect");

  c_general_write: cover property (accValid && accWrite && fld.grp == rbd_pkg::GRP_GENERAL);
  c_pixel_read: cover property (accValid && !accWrite && fld.grp == rbd_pkg::GRP_PIXEL);
  c_indirect_seq: cover property (accValid && indirectMode && fld.grp == rbd_pkg::GRP_SEQUENCER);
  c_unmapped: cover property (accValid && !fld.mapped);
endmodule

//--- rbd_address_decoder_tb.sv
// self-checking bench for the register group address decoder
// assumes the host model drives the address byte commands
`timescale 1ns/10ps
module rbd_address_decoder_tb;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic addrHiWe, addrLoWe;
  logic [7:0] addrByte;
  logic indirectMode = 1'b0;
  logic [7:0] offsetVal = 8'h00;
  logic accValid = 1'b0;
  logic accWrite = 1'b0;
  logic [7:0] accWdata = 8'h00;
  logic [7:0][7:0] grpRdata = 64'hC7B6A59483726150;
  logic [15:0] addrCur;
  logic [3:0] grpNum;
  logic [7:0] grpSel, grpWrStb, grpRdStb, wrData, rdData;
  logic [5:0] regIdx, regionAddr;
  logic [4:0] regMask;
  logic [2:0] frameIdx;
  logic regionFlag, halfSel, rdValid, unmappedAcc;
  int err_total = 0;
  int total_checks = 0;
  logic [3:0] grpTab [8] = '{rbd_pkg::GRP_GENERAL, rbd_pkg::GRP_CONVERTER, rbd_pkg::GRP_SEQUENCER,
    rbd_pkg::GRP_PIXEL, rbd_pkg::GRP_MONITOR, rbd_pkg::GRP_MFE, rbd_pkg::GRP_APIX, rbd_pkg::GRP_RDTEST};
  logic [3:0] badTab [5] = '{4'h0, 4'h5, 4'h6, 4'hB, 4'hF};
  // ****************************************
  // clock, design and host
  // ****************************************
  always #12.5 core_clk = ~core_clk;
  rbd_address_decoder dut_u (.core_clk(core_clk), .reset_n(reset_n), .addrHiWe(addrHiWe),
    .addrLoWe(addrLoWe), .addrByte(addrByte), .indirectMode(indirectMode), .offsetVal(offsetVal),
    .accValid(accValid), .accWrite(accWrite), .accWdata(accWdata), .grpRdata(grpRdata),
    .addrCur(addrCur), .grpNum(grpNum), .grpSel(grpSel), .regIdx(regIdx), .regionAddr(regionAddr),
    .regionFlag(regionFlag), .regMask(regMask), .frameIdx(frameIdx), .halfSel(halfSel),
    .grpWrStb(grpWrStb), .grpRdStb(grpRdStb), .wrData(wrData), .rdData(rdData), .rdValid(rdValid),
    .unmappedAcc(unmappedAcc));
  rbd_host_model host_u (.core_clk(core_clk), .addrHiWe(addrHiWe), .addrLoWe(addrLoWe), .addrByte(addrByte));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string msg);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic access(input logic wr, input logic [7:0] d);
    @(posedge core_clk);
    #1;
    accValid = 1'b1;
    accWrite = wr;
    accWdata = d;
    @(posedge core_clk);
    #1;
    accValid = 1'b0;
  endtask
  task automatic settle();
    @(posedge core_clk);
    #1;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic testGroups();
    logic [7:0] lo;
    for (int i = 0; i < 8; i++) begin
      lo = {grpTab[i][2:0], 5'h02};
      if (i == 0 || grpTab[i][3]) host_u.setAddr({grpTab[i][3], 7'h00}, lo);
      else host_u.setLow(lo);
      check(addrCur, {grpTab[i][3], 7'h00, lo}, "address");
      settle();
      check(grpNum, grpTab[i], "group");
      check(grpSel, 8'h01 << i, "select");
      access(1'b0, 8'h00);
      check({unmappedAcc, rdValid, grpRdStb, rdData}, {2'b01, 8'h01 << i, grpRdata[i]}, "read");
      access(1'b1, 8'h5A ^ i[7:0]);
      check(grpWrStb, (i == 4) ? 8'h00 : 8'h01 << i, "write");
      check(wrData, 8'h5A ^ i[7:0], "write data");
    end
    $display("test groups done");
  endtask
  task automatic testFields();
    host_u.setAddr(8'h6A, 8'h95);
    settle();
    check({regionFlag, regionAddr, regMask}, {1'b1, 6'h2A, 5'h15}, "pixel fields");
    host_u.setAddr(8'hD5, 8'h1D);
    settle();
    check({grpNum, regionAddr, frameIdx}, {4'h8, 6'h15, 3'h5}, "emulation fields");
    host_u.setAddr(8'hFF, 8'h3F);
    settle();
    check({grpNum, halfSel}, {4'h9, 1'b1}, "half select");
    host_u.setAddr(8'h7E, 8'h2B);
    settle();
    check({grpNum, regIdx}, {4'h1, 6'h0B}, "unused bits");
    $display("test fields done");
  endtask
  task automatic testIndirect();
    host_u.setAddr(8'h80, 8'h43);
    indirectMode = 1'b1;
    offsetVal = 8'h10;
    access(1'b0, 8'h00);
    check({unmappedAcc, rdValid, grpRdStb}, {2'b01, 8'h80}, "index 19");
    offsetVal = 8'h11;
    access(1'b1, 8'h33);
    check({unmappedAcc, grpWrStb}, {1'b1, 8'h00}, "index 20");
    host_u.setAddr(8'h00, 8'h2E);
    offsetVal = 8'h03;
    settle();
    settle();
    check(regIdx, 6'h01, "indirect index");
    host_u.setAddr(8'h01, 8'h7E);
    access(1'b0, 8'h00);
    check({regIdx, grpRdStb, rdData}, {6'h01, 8'h04, grpRdata[2]}, "indirect sequencer");
    indirectMode = 1'b0;
    $display("test indirect done");
  endtask
  task automatic testUnmapped();
    for (int i = 0; i < 5; i++) begin
      host_u.setAddr({badTab[i][3], 7'h00}, {badTab[i][2:0], 5'h00});
      access(1'b0, 8'h00);
      check({unmappedAcc, rdValid, grpRdStb, rdData}, {2'b11, 16'h0000}, "unmapped read");
      access(1'b1, 8'hFF);
      check({unmappedAcc, grpWrStb}, {1'b1, 8'h00}, "unmapped write");
    end
    $display("test unmapped done");
  endtask
  task automatic testReset();
    settle();
    reset_n = 1'b0;
    #2;
    check({addrCur, grpSel}, 24'h000000, "reset clears");
    settle();
    reset_n = 1'b1;
    host_u.setAddr(8'h00, 8'h21);
    settle();
    check({addrCur, grpSel}, {16'h0021, 8'h01}, "after reset");
    $display("test reset done");
  endtask
  // ****************************************
  // run control
  // ****************************************
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    #1;
    reset_n = 1'b1;
    testGroups();
    testFields();
    testIndirect();
    testUnmapped();
    testReset();
    end_of_test();
  end
  initial begin
    #(4000 * 25);
    err_total++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    end_of_test();
  end
endmodule

//--- rbd_field_decode.sv
// combinational split of the 16-bit address into group and per-group fields
// assumes address and offset are stable flip-flop outputs
`timescale 1ns/10ps
module rbd_field_decode (
  // fields
  rbd_field_if.dec f
);
  logic [5:0] off6;
  assign off6 = f.indirect ? f.offset[5:0] : 6'h00;

  always_comb begin
    f.grp = {f.addr[rbd_pkg::POS_GRP_HI], f.addr[rbd_pkg::POS_GRP_LO_MSB:rbd_pkg::POS_GRP_LO_LSB]};
    f.slot = rbd_pkg::SLOT_GENERAL;
    f.mapped = 1'b1;
    f.regIdx = 6'h00;
    f.region = 6'h00;
    f.regionFlag = 1'b0;
    f.mask = 5'h00;
    f.frame = 3'h0;
    f.half = 1'b0;
    // unused bits never enter a field
    case (f.grp)
      rbd_pkg::GRP_GENERAL, rbd_pkg::GRP_CONVERTER, rbd_pkg::GRP_MONITOR: begin
        f.regIdx = {2'b00, f.addr[3:0] + off6[3:0]};
        f.slot = (f.grp == rbd_pkg::GRP_GENERAL) ? rbd_pkg::SLOT_GENERAL :
                 (f.grp == rbd_pkg::GRP_CONVERTER) ? rbd_pkg::SLOT_CONVERTER : rbd_pkg::SLOT_MONITOR;
      end
      rbd_pkg::GRP_SEQUENCER: begin
        f.regIdx = {f.addr[rbd_pkg::POS_SEQ_HI], f.addr[4:0]} + off6;
        f.slot = rbd_pkg::SLOT_SEQUENCER;
      end
      rbd_pkg::GRP_PIXEL: begin
        f.regionFlag = f.addr[rbd_pkg::POS_FLAG];
        f.region = f.addr[rbd_pkg::POS_REGION_MSB:rbd_pkg::POS_REGION_LSB] + off6;
        f.mask = f.addr[4:0];
        f.slot = rbd_pkg::SLOT_PIXEL;
      end
      rbd_pkg::GRP_MFE: begin
        f.region = f.addr[rbd_pkg::POS_REGION_MSB:rbd_pkg::POS_REGION_LSB] + off6;
        f.frame = f.addr[2:0];
        f.slot = rbd_pkg::SLOT_MFE;
      end
      rbd_pkg::GRP_APIX: begin
        f.half = f.addr[0] ^ off6[0];
        f.slot = rbd_pkg::SLOT_APIX;
      end
      rbd_pkg::GRP_RDTEST: begin
        f.regIdx = {1'b0, f.addr[4:0] + off6[4:0]};
        f.mapped = (f.regIdx[4:0] <= rbd_pkg::RDTEST_MAX);
        f.slot = rbd_pkg::SLOT_RDTEST;
      end
      default: begin
        f.mapped = 1'b0;
      end
    endcase
  end
endmodule

//--- rbd_field_if.sv
// carries the held address and its decoded fields between decoder modules
// assumes both ends sit in the core_clk domain
`timescale 1ns/10ps
interface rbd_field_if;
  logic [15:0] addr;
  logic [7:0] offset;
  logic indirect;
  logic [3:0] grp;
  logic [2:0] slot;
  logic mapped;
  logic [5:0] regIdx;
  logic [5:0] region;
  logic regionFlag;
  logic [4:0] mask;
  logic [2:0] frame;
  logic half;
  modport dec (input addr, offset, indirect,
    output grp, slot, mapped, regIdx, region, regionFlag, mask, frame, half);
  modport user (output addr, offset, indirect,
    input grp, slot, mapped, regIdx, region, regionFlag, mask, frame, half);
endinterface

//--- rbd_host_model.sv
// host model issuing the upper and lower address byte commands
// assumes the device samples its inputs on the rising edge of core_clk
`timescale 1ns/10ps
module rbd_host_model (
  // clock
  input wire logic core_clk,
  // address byte commands
  output logic addrHiWe,
  output logic addrLoWe,
  output logic [7:0] addrByte
);
  // ****************************************
  // command sequencing
  // ****************************************
  initial begin
    addrHiWe = 1'b0;
    addrLoWe = 1'b0;
    addrByte = 8'h00;
  end
  // lower byte only, once the upper byte is in place
  task automatic setLow(input logic [7:0] lo);
    @(posedge core_clk);
    #1;
    addrLoWe = 1'b1;
    addrByte = lo;
    @(posedge core_clk);
    #1;
    addrLoWe = 1'b0;
    addrByte = ~lo;
  endtask
  // upper byte carries group bit 3, lower byte group bits 2 to 0
  task automatic setAddr(input logic [7:0] hi, input logic [7:0] lo);
    @(posedge core_clk);
    #1;
    addrHiWe = 1'b1;
    addrByte = hi;
    @(posedge core_clk);
    #1;
    addrHiWe = 1'b0;
    addrLoWe = 1'b1;
    addrByte = lo;
    @(posedge core_clk);
    #1;
    addrLoWe = 1'b0;
    addrByte = ~lo;
  endtask
endmodule

//--- rbd_pkg.sv
// constants shared by the register group address decoder
// assumes one 40 MHz clock and an address built from two byte commands
//
// Function
// - The register address is 16 bits, loaded as an upper and a lower byte, and targets later reads and writes.
// - The group number is 4 bits: bit 3 is address bit 15 and bits 2 to 0 are address bits 7 to 5.
// - Group 1 is the general configuration, read-write, indexed by a 4-bit register index in the low bits.
// - Group 3 is the sequencer configuration and group 2 the converter values, both read-write.
// - Group 4 is pixel control with a region-group flag, a 6-bit region address and a 5-bit register mask.
// - Group 7 is monitoring, read-only, and writes there change nothing.
// - Group 8 is multi-frame emulation storage with a 6-bit region address and a 3-bit frame index.
// - Group 9 is analogue pixel selection where address bit 0 picks the upper or lower half.
// - Group 10 is the readout test configuration with a 5-bit register index valid from 0 to 19.
// - Unused address bits are ignored so either value selects the same register.
// - In indirect mode the index, region and half fields are combined with the offset value.
package rbd_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int GRP_W = 4;
  localparam int SLOT_N = 8;
  // ****************************************
  // group numbers
  // ****************************************
  localparam logic [3:0] GRP_GENERAL = 4'h1;
  localparam logic [3:0] GRP_CONVERTER = 4'h2;
  localparam logic [3:0] GRP_SEQUENCER = 4'h3;
  localparam logic [3:0] GRP_PIXEL = 4'h4;
  localparam logic [3:0] GRP_MONITOR = 4'h7;
  localparam logic [3:0] GRP_MFE = 4'h8;
  localparam logic [3:0] GRP_APIX = 4'h9;
  localparam logic [3:0] GRP_RDTEST = 4'hA;
  // ****************************************
  // slot indices of the one-hot group strobes
  // ****************************************
  localparam logic [2:0] SLOT_GENERAL = 3'h0;
  localparam logic [2:0] SLOT_CONVERTER = 3'h1;
  localparam logic [2:0] SLOT_SEQUENCER = 3'h2;
  localparam logic [2:0] SLOT_PIXEL = 3'h3;
  localparam logic [2:0] SLOT_MONITOR = 3'h4;
  localparam logic [2:0] SLOT_MFE = 3'h5;
  localparam logic [2:0] SLOT_APIX = 3'h6;
  localparam logic [2:0] SLOT_RDTEST = 3'h7;
  // ****************************************
  // field positions
  // ****************************************
  localparam int POS_GRP_HI = 15;
  localparam int POS_GRP_LO_MSB = 7;
  localparam int POS_GRP_LO_LSB = 5;
  localparam int POS_FLAG = 14;
  localparam int POS_REGION_MSB = 13;
  localparam int POS_REGION_LSB = 8;
  localparam int POS_SEQ_HI = 8;
  localparam logic [4:0] RDTEST_MAX = 5'h13;
  localparam logic [15:0] ADDR_RESET = 16'h0000;
endpackage
